/* rtl/dbbs_top.sv */
// Dual-bank boot selector: boot space decision, flash probe and Avalon-MM status
`timescale 1ns/100ps
`include "dbbs_cfg.svh"
module dbbs_top #(
  parameter logic [31:0] BANK1_BASE = `DBBS_BANK1_BASE,
  parameter logic [31:0] BANK2_BASE = `DBBS_BANK2_BASE,
  parameter logic [31:0] SRAM_BASE = `DBBS_SRAM_BASE,
  parameter logic [31:0] SRAM_BYTES = `DBBS_SRAM_BYTES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic boot_select_pin_zero_i,
  input wire logic boot_select_pin_one_i,
  input wire logic highest_read_protection_i,
  output logic flash_rd_req_o,
  output logic [31:0] flash_rd_addr_o,
  input wire logic flash_rd_valid_i,
  input wire logic [31:0] flash_rd_data_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [2:0] boot_space_o,
  output logic boot_done_o,
  output logic cpu_halt_o,
  output logic dual_check_o,
  output logic bootloader_run_o,
  output logic boot_alias_en_o
);

  dbbs_pkg::dbbs_state_e state_r;
  dbbs_pkg::dbbs_state_e state_nxt;
  dbbs_pkg::dbbs_space_e space_r;
  dbbs_pkg::dbbs_space_e space_nxt;
  logic [1:0] pins_sync;
  logic [1:0] settle_cnt_r;
  logic settle_done;
  logic boot_select_pin_zero_r;
  logic boot_select_pin_one_r;
  logic highest_read_protection_r;
  logic bank_flip_boot_flag_r;
  logic [31:0] opt_word_r;
  logic sp_ok;
  logic bank2_ok_r;
  logic bank1_ok_r;
  logic dual_ran_r;
  logic halt_r;
  logic halt_nxt;
  logic [31:0] addr_r;
  logic [31:0] addr_nxt;
  logic done_r;
  logic dual_check_r;
  logic boot_run_r;
  logic alias_en_r;
  logic ctrl_alias_r;
  logic bus_req;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [31:0] status_word;

  dbbs_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({boot_select_pin_one_i, boot_select_pin_zero_i}),
    .sync_o(pins_sync)
  );

  dbbs_sp_check #(
    .SRAM_BASE(SRAM_BASE),
    .SRAM_BYTES(SRAM_BYTES)
  ) u_sp_check (
    .word_i(flash_rd_data_i),
    .valid_o(sp_ok)
  );

  // Let the synchroniser fill before the pins are trusted
  assign settle_done = (settle_cnt_r == `DBBS_SETTLE_CYC);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      settle_cnt_r <= 2'h0;
    else if (state_r == dbbs_pkg::S_SETTLE && !settle_done)
      settle_cnt_r <= 2'(settle_cnt_r + 2'h1);
  end

  // Inputs caught once per reset, never resampled
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      boot_select_pin_zero_r <= 1'b0;
      boot_select_pin_one_r <= 1'b0;
      highest_read_protection_r <= 1'b0;
    end
    else if (state_r == dbbs_pkg::S_SETTLE && settle_done)
    begin
      boot_select_pin_zero_r <= pins_sync[0];
      boot_select_pin_one_r <= pins_sync[1];
      highest_read_protection_r <= highest_read_protection_i;
    end
  end

  // Unprogrammed option defaults to flag set until the word arrives
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bank_flip_boot_flag_r <= 1'b1;
      opt_word_r <= 32'h0000_0000;
    end
    else if (state_r == dbbs_pkg::S_OPT && flash_rd_valid_i)
    begin
      bank_flip_boot_flag_r <= flash_rd_data_i[`DBBS_FLIP_BIT];
      opt_word_r <= flash_rd_data_i;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    space_nxt = space_r;
    halt_nxt = halt_r;
    addr_nxt = addr_r;
    case (state_r)
      dbbs_pkg::S_SETTLE:
      begin
        if (settle_done)
        begin
          state_nxt = dbbs_pkg::S_OPT;
          addr_nxt = `DBBS_OPT_WORD_ADDR;
        end
      end
      dbbs_pkg::S_OPT:
      begin
        if (flash_rd_valid_i)
          state_nxt = dbbs_pkg::S_DECIDE;
      end
      dbbs_pkg::S_DECIDE:
      begin
        if (!boot_select_pin_zero_r || highest_read_protection_r)
        begin
          if (bank_flip_boot_flag_r)
          begin
            state_nxt = dbbs_pkg::S_DONE;
            space_nxt = dbbs_pkg::SPACE_BANK1;
          end
          else
          begin
            state_nxt = dbbs_pkg::S_BANK2;
            addr_nxt = BANK2_BASE;
          end
        end
        else if (!boot_select_pin_one_r)
        begin
          state_nxt = dbbs_pkg::S_DONE;
          space_nxt = dbbs_pkg::SPACE_SYSMEM;
        end
        else
        begin
          state_nxt = dbbs_pkg::S_DONE;
          space_nxt = dbbs_pkg::SPACE_SRAM;
        end
      end
      dbbs_pkg::S_BANK2:
      begin
        if (flash_rd_valid_i)
        begin
          if (sp_ok)
          begin
            state_nxt = dbbs_pkg::S_DONE;
            space_nxt = dbbs_pkg::SPACE_BANK2;
          end
          else
          begin
            state_nxt = dbbs_pkg::S_BANK1;
            addr_nxt = BANK1_BASE;
          end
        end
      end
      dbbs_pkg::S_BANK1:
      begin
        if (flash_rd_valid_i)
        begin
          state_nxt = dbbs_pkg::S_DONE;
          if (sp_ok)
            space_nxt = dbbs_pkg::SPACE_BANK1;
          else if (highest_read_protection_r)
            halt_nxt = 1'b1;
          else
            space_nxt = dbbs_pkg::SPACE_SYSMEM;
        end
      end
      dbbs_pkg::S_DONE:
      begin
        state_nxt = dbbs_pkg::S_DONE;
      end
      default:
      begin
        state_nxt = dbbs_pkg::S_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= dbbs_pkg::S_SETTLE;
      space_r <= dbbs_pkg::SPACE_NONE;
      halt_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      done_r <= 1'b0;
      dual_check_r <= 1'b0;
      boot_run_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      space_r <= space_nxt;
      halt_r <= halt_nxt;
      addr_r <= addr_nxt;
      done_r <= (state_nxt == dbbs_pkg::S_DONE);
      dual_check_r <= (state_nxt == dbbs_pkg::S_BANK2) || (state_nxt == dbbs_pkg::S_BANK1);
      boot_run_r <= (state_nxt == dbbs_pkg::S_DONE) && (space_nxt == dbbs_pkg::SPACE_SYSMEM);
    end
  end

  // Probe results kept for software diagnosis
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bank2_ok_r <= 1'b0;
      bank1_ok_r <= 1'b0;
      dual_ran_r <= 1'b0;
    end
    else
    begin
      if (state_r == dbbs_pkg::S_BANK2 && flash_rd_valid_i)
      begin
        bank2_ok_r <= sp_ok;
        dual_ran_r <= 1'b1;
      end
      if (state_r == dbbs_pkg::S_BANK1 && flash_rd_valid_i)
        bank1_ok_r <= sp_ok;
    end
  end

  // Request held until the flash answers; no timeout, a dead flash stalls boot
  assign flash_rd_req_o = (state_r == dbbs_pkg::S_OPT) || (state_r == dbbs_pkg::S_BANK2) ||
                          (state_r == dbbs_pkg::S_BANK1);
  assign flash_rd_addr_o = addr_r;
  assign boot_space_o = space_r;
  assign boot_done_o = done_r;
  assign cpu_halt_o = halt_r;
  assign dual_check_o = dual_check_r;
  assign bootloader_run_o = boot_run_r;
  assign boot_alias_en_o = alias_en_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alias_en_r <= 1'b0;
    else
      alias_en_r <= done_r && ctrl_alias_r && !halt_r;
  end

  // Avalon-MM slave: every access answers one cycle after it is seen
  assign bus_req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !ack_r;
  assign avs_readdata_o = readdata_r;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`DBBS_ST_SPACE_LSB +: 3] = space_r;
    status_word[`DBBS_ST_DONE_BIT] = done_r;
    status_word[`DBBS_ST_HALT_BIT] = halt_r;
    status_word[`DBBS_ST_FLAG_BIT] = bank_flip_boot_flag_r;
    status_word[`DBBS_ST_PIN0_BIT] = boot_select_pin_zero_r;
    status_word[`DBBS_ST_PIN1_BIT] = boot_select_pin_one_r;
    status_word[`DBBS_ST_PROT_BIT] = highest_read_protection_r;
    status_word[`DBBS_ST_B2OK_BIT] = bank2_ok_r;
    status_word[`DBBS_ST_B1OK_BIT] = bank1_ok_r;
    status_word[`DBBS_ST_DUAL_BIT] = dual_ran_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req && !ack_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      readdata_r <= 32'h0000_0000;
    else if (avs_read_i && !ack_r)
    begin
      case (avs_address_i)
        `DBBS_REG_STATUS: readdata_r <= status_word;
        `DBBS_REG_CTRL: readdata_r <= {31'h0000_0000, ctrl_alias_r};
        `DBBS_REG_OPTION: readdata_r <= opt_word_r;
        default: readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_alias_r <= `DBBS_CTRL_RESET;
    else if (avs_write_i && ack_r && avs_address_i == `DBBS_REG_CTRL && avs_byteenable_i[0])
      ctrl_alias_r <= avs_writedata_i[`DBBS_CTRL_ALIAS_BIT];
  end

  sequence s_decide_dual;
    state_r == dbbs_pkg::S_DECIDE && !bank_flip_boot_flag_r &&
      (!boot_select_pin_zero_r || highest_read_protection_r);
  endsequence

  sequence s_bank2_seen;
    state_r == dbbs_pkg::S_BANK2 && flash_rd_valid_i;
  endsequence

  sequence s_bank1_seen;
    state_r == dbbs_pkg::S_BANK1 && flash_rd_valid_i;
  endsequence

  property p_opt_fetch;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_r == dbbs_pkg::S_OPT && flash_rd_valid_i) |->
      flash_rd_addr_o == `DBBS_OPT_WORD_ADDR ##1
      bank_flip_boot_flag_r == $past(flash_rd_data_i[`DBBS_FLIP_BIT]);
  endproperty
  a_opt_fetch: assert property (p_opt_fetch) else $error("option flag not taken");

  property p_dual_entry;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_decide_dual |=> state_r == dbbs_pkg::S_BANK2 && dual_check_o &&
      flash_rd_addr_o == BANK2_BASE;
  endproperty
  a_dual_entry: assert property (p_dual_entry) else $error("dual check not started");

  property p_bank2_jump;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_bank2_seen and sp_ok) |=> boot_space_o == dbbs_pkg::SPACE_BANK2 && boot_done_o
      ##1 boot_alias_en_o == ctrl_alias_r;
  endproperty
  a_bank2_jump: assert property (p_bank2_jump) else $error("bank 2 not selected");

  property p_bank1_probe;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_bank2_seen and !sp_ok) |=> state_r == dbbs_pkg::S_BANK1 &&
      flash_rd_addr_o == BANK1_BASE;
  endproperty
  a_bank1_probe: assert property (p_bank1_probe) else $error("bank 1 not probed");

  property p_bank1_jump;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_bank1_seen and sp_ok) |=> boot_space_o == dbbs_pkg::SPACE_BANK1 && !bootloader_run_o;
  endproperty
  a_bank1_jump: assert property (p_bank1_jump) else $error("bank 1 not selected");

  property p_no_valid_bank;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_bank1_seen and !sp_ok && !highest_read_protection_r) |=>
      boot_space_o == dbbs_pkg::SPACE_SYSMEM && bootloader_run_o && !cpu_halt_o;
  endproperty
  a_no_valid_bank: assert property (p_no_valid_bank) else $error("no bootloader fallback");

  property p_halt;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_bank1_seen and !sp_ok && highest_read_protection_r) |=>
      (cpu_halt_o && !bootloader_run_o) [*3];
  endproperty
  a_halt: assert property (p_halt) else $error("protected part not halted");

  property p_flag_skip;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_r == dbbs_pkg::S_DECIDE && bank_flip_boot_flag_r) |=>
      boot_done_o && !dual_check_o && !dual_ran_r;
  endproperty
  a_flag_skip: assert property (p_flag_skip) else $error("dual check not skipped");

  property p_probe_valid;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_bank2_seen |=> bank2_ok_r == ($past(flash_rd_data_i) >= SRAM_BASE &&
      $past(flash_rd_data_i) <= 32'(SRAM_BASE + SRAM_BYTES));
  endproperty
  a_probe_valid: assert property (p_probe_valid) else $error("stack check wrong");

  property p_flag_bank1;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_r == dbbs_pkg::S_DECIDE && bank_flip_boot_flag_r &&
      (!boot_select_pin_zero_r || highest_read_protection_r)) |=>
      boot_space_o == dbbs_pkg::SPACE_BANK1;
  endproperty
  a_flag_bank1: assert property (p_flag_bank1) else $error("bank 1 alias missing");

  property p_pins_sysmem_sram;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_r == dbbs_pkg::S_DECIDE && !highest_read_protection_r && boot_select_pin_zero_r) |=>
      boot_space_o == (boot_select_pin_one_r ? dbbs_pkg::SPACE_SRAM : dbbs_pkg::SPACE_SYSMEM);
  endproperty
  a_pins_sysmem_sram: assert property (p_pins_sysmem_sram) else $error("pin space wrong");

  property p_user_code;
    @(posedge clk_i) disable iff (!rst_n_i)
    (boot_done_o && dual_ran_r && (bank2_ok_r || bank1_ok_r)) |-> !bootloader_run_o && !cpu_halt_o;
  endproperty
  a_user_code: assert property (p_user_code) else $error("bootloader with valid bank");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    boot_done_o |=> boot_done_o && $stable(boot_space_o) && $stable(cpu_halt_o);
  endproperty
  a_hold: assert property (p_hold) else $error("decision changed after done");

  property p_bus_answer;
    @(posedge clk_i) disable iff (!rst_n_i)
    (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus not answered");

endmodule

/* inc/dbbs_cfg.svh */
// Constants of the dual-bank boot selector: addresses, register map, fields, counts
// Overview of operation
// - Bank-flip flag is bit 7 of the option word at 0x1FF8_0004.
// - Flag clear, pin zero low: start in system memory, run dual-bank check.
// - Dual-bank check tests bank 2 first; valid bank 2 becomes boot space.
// - Bank 2 invalid: test bank 1; valid bank 1 becomes boot space.
// - No valid bank, no protection: normal bootloader from system memory, no jump to flash.
// - Flag set (its default) skips the dual-bank check entirely.
// - Bank valid only when its first word points inside internal SRAM.
// - Flag set: bank 1 when pin zero low, or pin zero high with protection.
// - No protection, pin zero high, pin one low: system memory, any flag.
// - No protection, both pins high: embedded SRAM is boot space.
// - Flag clear with highest protection: dual-bank check whatever the pins.
// - Flag clear, highest protection and no valid bank: halt the processor.
// - Flag clear with a valid bank, once the dual-bank check runs: jump to user code.
`ifndef DBBS_CFG_SVH
`define DBBS_CFG_SVH

`define DBBS_OPT_WORD_ADDR 32'h1ff8_0004
`define DBBS_FLIP_BIT 7
`define DBBS_BANK1_BASE 32'h0800_0000
`define DBBS_BANK2_BASE 32'h0803_0000
`define DBBS_SRAM_BASE 32'h2000_0000
`define DBBS_SRAM_BYTES 32'h0000_4000

`define DBBS_REG_STATUS 4'h0
`define DBBS_REG_CTRL 4'h4
`define DBBS_REG_OPTION 4'h8

`define DBBS_ST_SPACE_LSB 0
`define DBBS_ST_DONE_BIT 3
`define DBBS_ST_HALT_BIT 4
`define DBBS_ST_FLAG_BIT 5
`define DBBS_ST_PIN0_BIT 6
`define DBBS_ST_PIN1_BIT 7
`define DBBS_ST_PROT_BIT 8
`define DBBS_ST_B2OK_BIT 9
`define DBBS_ST_B1OK_BIT 10
`define DBBS_ST_DUAL_BIT 11

`define DBBS_CTRL_ALIAS_BIT 0
`define DBBS_CTRL_RESET 1'b1

`define DBBS_SETTLE_CYC 2'h2

`endif

/* inc/dbbs_pkg.sv */
// Types of the dual-bank boot selector
package dbbs_pkg;

  typedef enum logic [5:0]
  {
    S_SETTLE = 6'h01,
    S_OPT    = 6'h02,
    S_DECIDE = 6'h04,
    S_BANK2  = 6'h08,
    S_BANK1  = 6'h10,
    S_DONE   = 6'h20
  } dbbs_state_e;

  typedef enum logic [2:0]
  {
    SPACE_NONE   = 3'h0,
    SPACE_BANK1  = 3'h1,
    SPACE_BANK2  = 3'h2,
    SPACE_SYSMEM = 3'h3,
    SPACE_SRAM   = 3'h4
  } dbbs_space_e;

endpackage

/* rtl/dbbs_sync.sv */
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module dbbs_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

/* rtl/dbbs_sp_check.sv */
// Initial stack pointer range check against internal SRAM
`timescale 1ns/100ps
`include "dbbs_cfg.svh"
module dbbs_sp_check #(
  parameter logic [31:0] SRAM_BASE = `DBBS_SRAM_BASE,
  parameter logic [31:0] SRAM_BYTES = `DBBS_SRAM_BYTES
) (
  input wire logic [31:0] word_i,
  output logic valid_o
);

  // Stack top may equal the SRAM end for a full descending stack
  localparam logic [31:0] SRAM_TOP = 32'(SRAM_BASE + SRAM_BYTES);

  assign valid_o = (word_i >= SRAM_BASE) && (word_i <= SRAM_TOP);

endmodule

/* verification/test_dual_bank_boot_selector.sv */
// Self-checking bench for the dual-bank boot selector
`timescale 1ns/100ps
`include "dbbs_cfg.svh"
module test_dual_bank_boot_selector;
  localparam logic [31:0] SB = `DBBS_SRAM_BASE;
  localparam logic [31:0] ST = `DBBS_SRAM_BASE + `DBBS_SRAM_BYTES;
  logic clk_i, rst_n_i, pin0, pin1, prot, fvalid;
  logic [31:0] fdata, faddr, opt_w, w2, w1;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic avs_read_i, avs_write_i, freq, wreq, done, halt, dual, brun, alias_en;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [2:0] space;
  logic [1:0] lat;
  logic [31:0] fetched[$];
  integer seed = 32'h725b;
  int failures, samples_checked;

  dbbs_top DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .boot_select_pin_zero_i(pin0),
    .boot_select_pin_one_i(pin1), .highest_read_protection_i(prot),
    .flash_rd_req_o(freq), .flash_rd_addr_o(faddr), .flash_rd_valid_i(fvalid),
    .flash_rd_data_i(fdata), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(wreq), .boot_space_o(space), .boot_done_o(done),
    .cpu_halt_o(halt), .dual_check_o(dual), .bootloader_run_o(brun),
    .boot_alias_en_o(alias_en)
  );

  always #2 clk_i = ~clk_i;

  function automatic logic [31:0] lookup(input logic [31:0] a);
    if (a === `DBBS_OPT_WORD_ADDR) return opt_w;
    if (a === `DBBS_BANK2_BASE) return w2;
    if (a === `DBBS_BANK1_BASE) return w1;
    return 32'hdead_beef;
  endfunction

  // Flash answers after 0..2 idle cycles; data toggles outside a fetch so stale words never pass
  always @(posedge clk_i)
  begin
    if (fvalid || freq !== 1'b1)
    begin
      fvalid <= 1'b0;
      fdata <= ~fdata;
      lat <= 2'($unsigned($random(seed)) % 3);
    end
    else if (lat != 2'h0)
    begin
      lat <= lat - 2'h1;
      fdata <= ~fdata;
    end
    else
    begin
      fvalid <= 1'b1;
      fdata <= lookup(faddr);
      fetched.push_back(faddr);
    end
  end

  task results;
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [3:0] be,
                    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_byteenable_i <= be;
    avs_writedata_i <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      failures++;
      results();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // Stack word inside SRAM, top inclusive, or outside it
  function automatic logic [31:0] sp_word(input logic ok);
    logic [31:0] r;
    r = $random(seed);
    case (r[1:0])
      2'h0: return ok ? SB : SB - 32'h1;
      2'h1: return ok ? ST : ST + 32'h1;
      2'h2: return ok ? SB + (r % `DBBS_SRAM_BYTES) : 32'h0;
      default: return ok ? SB + 32'h4 : r | 32'h8000_0000;
    endcase
  endfunction

  // Returns {halt, space}
  function automatic logic [3:0] expect_boot(input logic [5:0] v);
    logic f, p0, p1, pr, v2, v1;
    {f, p0, p1, pr, v2, v1} = v;
    if (p0 && !pr)
      return {1'b0, p1 ? dbbs_pkg::SPACE_SRAM : dbbs_pkg::SPACE_SYSMEM};
    if (f)
      return {1'b0, dbbs_pkg::SPACE_BANK1};
    if (v2)
      return {1'b0, dbbs_pkg::SPACE_BANK2};
    if (v1)
      return {1'b0, dbbs_pkg::SPACE_BANK1};
    return pr ? {1'b1, dbbs_pkg::SPACE_NONE} : {1'b0, dbbs_pkg::SPACE_SYSMEM};
  endfunction

  task automatic boot(input logic [5:0] v);
    logic f, p0, p1, pr, v2, v1, dc, seen;
    logic [3:0] e;
    logic [31:0] rd, est;
    int n;
    {f, p0, p1, pr, v2, v1} = v;
    opt_w = $random(seed);
    opt_w[`DBBS_FLIP_BIT] = f;
    w2 = sp_word(v2);
    w1 = sp_word(v1);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    pin0 <= p0;
    pin1 <= p1;
    prot <= pr;
    repeat (4) @(posedge clk_i);
    fetched.delete();
    rst_n_i <= 1'b1;
    seen = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
      if (dual === 1'b1)
        seen = 1'b1;
    end
    if (n >= 300)
    begin
      failures++;
      results();
    end
    repeat (2) @(posedge clk_i);
    dc = !f && (!p0 || pr);
    e = expect_boot(v);
    chk("boot_space", {29'h0, e[2:0]}, {29'h0, space});
    chk("cpu_halt", {31'h0, e[3]}, {31'h0, halt});
    chk("bootloader_run", {31'h0, e[2:0] == dbbs_pkg::SPACE_SYSMEM}, {31'h0, brun});
    chk("alias_en", {31'h0, !e[3]}, {31'h0, alias_en});
    chk("dual_check_seen", {31'h0, dc}, {31'h0, seen});
    chk("fetch_count", !dc ? 1 : (v2 ? 2 : 3), fetched.size());
    if (fetched.size() > 1)
      chk("fetch_bank2", `DBBS_BANK2_BASE, fetched[1]);
    if (fetched.size() > 2)
      chk("fetch_bank1", `DBBS_BANK1_BASE, fetched[2]);
    // Bank 1 is only probed when bank 2 failed
    est = {20'h0, dc, dc & !v2 & v1, dc & v2, pr, p1, p0, f, e[3], 1'b1, e[2:0]};
    av(1'b0, `DBBS_REG_STATUS, 4'hf, 32'h0, rd);
    chk("status", est, rd);
    av(1'b0, `DBBS_REG_OPTION, 4'hf, 32'h0, rd);
    chk("option", opt_w, rd);
    pin0 <= ~p0;
    pin1 <= ~p1;
    prot <= ~pr;
    repeat (8) @(posedge clk_i);
    chk("held_space", {29'h0, e[2:0]}, {29'h0, space});
    chk("held_done", 32'h1, {31'h0, done});
  endtask

  initial
  begin
    logic [31:0] rd, st;
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    {pin0, pin1, prot, fvalid, avs_read_i, avs_write_i} = 6'h0;
    {fdata, opt_w, w1, w2, avs_writedata_i} = {5{32'h0}};
    avs_address_i = 4'h0;
    avs_byteenable_i = 4'h0;
    lat = 2'h0;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 64; i++)
      boot(6'(i));
    boot(6'h20);
    av(1'b1, `DBBS_REG_CTRL, 4'he, $random(seed) & 32'hffff_fffe, rd);
    repeat (2) @(posedge clk_i);
    chk("alias_be_off", 32'h1, {31'h0, alias_en});
    av(1'b1, `DBBS_REG_CTRL, 4'h1, 32'h0, rd);
    repeat (2) @(posedge clk_i);
    chk("alias_off", 32'h0, {31'h0, alias_en});
    av(1'b0, `DBBS_REG_CTRL, 4'hf, 32'h0, rd);
    chk("ctrl", 32'h0, rd & 32'h1);
    av(1'b0, 4'hc, 4'hf, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    av(1'b0, `DBBS_REG_STATUS, 4'hf, 32'h0, st);
    av(1'b1, `DBBS_REG_STATUS, 4'hf, 32'hffff_ffff, rd);
    av(1'b0, `DBBS_REG_STATUS, 4'hf, 32'h0, rd);
    chk("status_ro", st, rd);
    av(1'b1, `DBBS_REG_CTRL, 4'hf, 32'h1, rd);
    repeat (2) @(posedge clk_i);
    chk("alias_on", 32'h1, {31'h0, alias_en});
    results();
  end
endmodule
